// ==== core/clock_ctrl_defs.svh ====
`ifndef CLOCK_CTRL_DEFS_SVH
`define CLOCK_CTRL_DEFS_SVH

// Timing base
`define CLK_PERIOD_NS     10
`define NS_PER_MS         1000000
`define DLY_SHORT_MS      4
`define DLY_LONG_MS       64

// Oscillator start-up and reset counts, in source clock cycles
`define OSC_CK_RC         24'h00_0006
`define OSC_CK_258        24'h00_0102
`define OSC_CK_1K         24'h00_0400
`define OSC_CK_16K        24'h00_4000
`define RESET_CK_14       24'h00_000E

// Configuration fields
`define SRC_XTAL_BIT      3
`define SRC_LOWFREQ_XTAL  4'h6
`define SRC_RANGE_MSB     2
`define SRC_RANGE_LSB     1

// Configuration as delivered
`define SHIP_SOURCE_SEL   4'h2
`define SHIP_STARTUP      2'h2
`define SHIP_DIV8         1'b1
`define SHIP_CLKOUT       1'b0

// Prescale control register
`define PCR_EN_BIT        7
`define PCR_SEL_MSB       3
`define PS_RESET_DIV8     4'h3
`define PS_RESET_DIV1     4'h0
`define PS_MAX_CODE       4'h8
`define PS_LIMIT_MAX      8'hFF
`define PS_EN_TICKS       3'h4

`endif

// ==== core/clock_ctrl_pkg.sv ====
package clock_ctrl_pkg;

    typedef enum logic [1:0] {
        RANGE_0P4_0P9,
        RANGE_0P9_3P0,
        RANGE_3P0_8P0,
        RANGE_8P0_UP
    } osc_range_type;

    typedef enum logic [1:0] {
        EXTRA_NONE,
        EXTRA_SHORT,
        EXTRA_LONG
    } extra_delay_type;

    typedef struct packed {
        logic [3:0] source_select_cfg;
        logic [1:0] startup_time_cfg;
        logic       div_by_eight_cfg;
        logic       clock_out_cfg;
    } fuse_cfg_type;

    typedef struct packed {
        logic [23:0]     osc_cycles;
        extra_delay_type extra;
    } startup_delay_type;

    typedef struct packed {
        logic data;
        logic oe_n;
    } pad_drive_type;

endpackage

// ==== core/prescale_ripple.sv ====
`timescale 1ns/1ps
`include "clock_ctrl_defs.svh"

module prescale_ripple
    import clock_ctrl_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       load,
    input  wire logic [7:0] new_limit,
    output logic            tick,
    output logic            loaded
);

    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] limit_reg;
    logic [7:0] limit_next;
    logic       tick_next;
    logic       loaded_next;

    // A new period length is taken only at a wrap, so every period is whole.
    // Tick flags the wrap due at the coming edge; one stage less latency lets
    // a change made on a system edge still catch the very next wrap.
    always_comb begin
        count_next  = count_reg + 8'h01;
        limit_next  = limit_reg;
        loaded_next = 1'b0;
        if (count_reg >= limit_reg) begin // R10
            count_next = 8'h00;
            if (load) begin // R9
                limit_next  = new_limit;
                loaded_next = 1'b1;
            end
        end
        tick_next = (count_next >= limit_next);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_reg <= 8'h00;
            limit_reg <= 8'h00;
            tick      <= 1'b0;
            loaded    <= 1'b0;
        end else begin
            count_reg <= count_next;
            limit_reg <= limit_next;
            tick      <= tick_next;
            loaded    <= loaded_next;
        end
    end

endmodule

// ==== core/crystal_clock_prescale_output.sv ====
// Operation
// R1 - Upper source bits pick oscillator range
// R2 - Lowest range for ceramic resonators only
// R3 - Low source bit and field pick delays
// R4 - Low bit zero: 258/1K delay table
// R5 - Low bit one: 1K/16K delay table
// R6 - 258-cycle options only for slow resonators
// R7 - Shipped default: RC, long start, divide-by-eight
// R8 - Division applies to every system clock
// R9 - Division change is glitch free
// R10 - Prescaler counts at undivided source rate
// R11 - New rate active after one old, one new period
// R12 - Exactly two active edges during transition
// R13 - Clock-out option drives pin, overrides port
// R14 - No clock on pin during reset
// R15 - No clock output with crystal source
// R16 - Pin carries divided system clock
// R17 - Select codes divide by powers of two
// R18 - Change enable then select within four cycles
// R19 - Reset select from divide-by-eight option
// R20 - Gate clock until start-up count elapses
`timescale 1ns/1ps
`include "clock_ctrl_defs.svh"

module crystal_clock_prescale_output
    import clock_ctrl_pkg::*;
#(
    parameter int DLY_SHORT_CYC = `DLY_SHORT_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
    parameter int DLY_LONG_CYC  = `DLY_LONG_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
)
(
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire fuse_cfg_type  fuse_in,
    input  wire logic          power_down_req,
    input  wire logic          wake_req,
    input  wire logic          cpu_wr,
    input  wire logic [7:0]    cpu_wdata,
    input  wire logic          port_out_data,
    input  wire logic          port_out_oe_n,
    output logic               sys_clk_tick,
    output logic               clock_running,
    output osc_range_type      osc_range,
    output logic [7:0]         prescale_control_reg,
    output pad_drive_type      clock_out_pin
);

    typedef enum logic [2:0] {
        ST_LATCH,
        ST_OSC_WAIT,
        ST_EXTRA_WAIT,
        ST_RUN,
        ST_SLEEP
    } start_state_type;

    function automatic startup_delay_type startup_decode(input fuse_cfg_type cfg);
        startup_delay_type d;
        d.osc_cycles = `OSC_CK_RC;
        d.extra      = EXTRA_NONE;
        if (cfg.source_select_cfg[`SRC_XTAL_BIT]) begin // R3
            case ({cfg.source_select_cfg[0], cfg.startup_time_cfg})
                3'b000: begin // R4
                    d.osc_cycles = `OSC_CK_258;
                    d.extra      = EXTRA_SHORT;
                end
                3'b001: begin // R4
                    d.osc_cycles = `OSC_CK_258;
                    d.extra      = EXTRA_LONG;
                end
                3'b010: begin // R4
                    d.osc_cycles = `OSC_CK_1K;
                    d.extra      = EXTRA_NONE;
                end
                3'b011: begin // R4
                    d.osc_cycles = `OSC_CK_1K;
                    d.extra      = EXTRA_SHORT;
                end
                3'b100: begin // R5
                    d.osc_cycles = `OSC_CK_1K;
                    d.extra      = EXTRA_LONG;
                end
                3'b101: begin // R5
                    d.osc_cycles = `OSC_CK_16K;
                    d.extra      = EXTRA_NONE;
                end
                3'b110: begin // R5
                    d.osc_cycles = `OSC_CK_16K;
                    d.extra      = EXTRA_SHORT;
                end
                default: begin // R5
                    d.osc_cycles = `OSC_CK_16K;
                    d.extra      = EXTRA_LONG;
                end
            endcase
        end else begin
            // Other sources: short wake, reset extra set by the field
            case (cfg.startup_time_cfg)
                2'b00:   d.extra = EXTRA_NONE;
                2'b01:   d.extra = EXTRA_SHORT;
                default: d.extra = EXTRA_LONG;
            endcase
        end
        return d;
    endfunction

    function automatic logic [7:0] div_limit(input logic [3:0] sel);
        logic [8:0] f;
        f = 9'h001 << sel;
        // Reserved codes run at the slowest factor, the safe side
        if (sel > `PS_MAX_CODE) begin
            return `PS_LIMIT_MAX;
        end
        return 8'(f - 9'h001); // R17
    endfunction

    // Configuration captured after reset release
    fuse_cfg_type     cfg_reg;
    fuse_cfg_type     cfg_next;

    start_state_type  state_reg;
    start_state_type  state_next;
    logic [23:0]      delay_reg;
    logic [23:0]      delay_next;

    logic [3:0]       sel_reg;
    logic [3:0]       sel_next;
    logic             chg_en_reg;
    logic             chg_en_next;
    logic [2:0]       chg_cnt_reg;
    logic [2:0]       chg_cnt_next;
    logic             pending_reg;
    logic             pending_next;

    logic             sys_clk_tick_next;
    logic             clock_running_next;
    osc_range_type    osc_range_next;
    pad_drive_type    pin_next;

    logic             src_tick;
    logic             src_loaded;
    logic             wr_take;
    logic             crystal_src;
    startup_delay_type dly;
    logic [23:0]      extra_cycles;
    logic             wake_pending_reg;
    logic             wake_pending_next;

    // Next values go in directly so a write made on a system edge meets the coming wrap
    prescale_ripple u_ripple (
        .core_clk  (core_clk),
        .rst       (rst),
        .load      (pending_next),
        .new_limit (div_limit(sel_next)),
        .tick      (src_tick),
        .loaded    (src_loaded)
    );

    assign dly         = startup_decode(cfg_reg);
    assign crystal_src = cfg_reg.source_select_cfg[`SRC_XTAL_BIT] ||
                         (cfg_reg.source_select_cfg == `SRC_LOWFREQ_XTAL);
    // The core only sees writes on its own clock edges
    assign wr_take     = cpu_wr && sys_clk_tick;

    always_comb begin
        case (dly.extra)
            EXTRA_SHORT: extra_cycles = `RESET_CK_14 + 24'(DLY_SHORT_CYC);
            EXTRA_LONG:  extra_cycles = `RESET_CK_14 + 24'(DLY_LONG_CYC);
            default:     extra_cycles = `RESET_CK_14;
        endcase
    end

    // Start-up sequencing
    always_comb begin
        cfg_next   = cfg_reg;
        state_next = state_reg;
        delay_next = delay_reg;
        case (state_reg)
            ST_LATCH: begin
                cfg_next   = fuse_in;
                delay_next = 24'h00_0000;
                state_next = ST_OSC_WAIT;
            end
            ST_OSC_WAIT: begin
                if (delay_reg >= dly.osc_cycles - 24'h00_0001) begin // R20
                    delay_next = 24'h00_0000;
                    state_next = ST_EXTRA_WAIT;
                end else begin
                    delay_next = delay_reg + 24'h00_0001;
                end
            end
            ST_EXTRA_WAIT: begin
                if (delay_reg >= extra_cycles - 24'h00_0001) begin // R20
                    delay_next = 24'h00_0000;
                    state_next = ST_RUN;
                end else begin
                    delay_next = delay_reg + 24'h00_0001;
                end
            end
            ST_RUN: begin
                if (power_down_req) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_req) begin
                    delay_next = 24'h00_0000;
                    state_next = ST_OSC_WAIT;
                end
            end
            default: begin
                state_next = ST_LATCH;
            end
        endcase
        // Wake from power-down skips the extra reset delay
        if (state_reg == ST_OSC_WAIT && state_next == ST_EXTRA_WAIT && wake_pending_reg) begin
            state_next = ST_RUN;
        end
    end

    always_comb begin
        wake_pending_next = wake_pending_reg;
        if (state_reg == ST_SLEEP && wake_req) begin
            wake_pending_next = 1'b1;
        end else if (state_reg == ST_RUN) begin
            wake_pending_next = 1'b0;
        end
    end

    // Prescale control with timed change enable
    always_comb begin
        sel_next     = sel_reg;
        chg_en_next  = chg_en_reg;
        chg_cnt_next = chg_cnt_reg;
        pending_next = pending_reg;
        if (src_loaded) begin
            pending_next = 1'b0;
        end
        if (state_reg == ST_LATCH) begin
            sel_next     = fuse_in.div_by_eight_cfg ? `PS_RESET_DIV8 : `PS_RESET_DIV1; // R19
            pending_next = 1'b1;
        end else begin
            if (chg_en_reg && sys_clk_tick) begin
                chg_cnt_next = chg_cnt_reg - 3'h1;
                if (chg_cnt_reg == 3'h1) begin
                    chg_en_next = 1'b0; // R18
                end
            end
            if (wr_take) begin
                if (cpu_wdata == (8'h01 << `PCR_EN_BIT)) begin
                    // Rewrite inside the window neither extends nor clears it
                    if (!chg_en_reg) begin
                        chg_en_next  = 1'b1; // R18
                        chg_cnt_next = `PS_EN_TICKS;
                    end
                end else if (chg_en_reg && !cpu_wdata[`PCR_EN_BIT]) begin
                    sel_next     = cpu_wdata[`PCR_SEL_MSB:0]; // R18
                    chg_en_next  = 1'b0;
                    pending_next = 1'b1; // R11
                end
            end
        end
    end

    // Output stage
    always_comb begin
        clock_running_next = (state_next == ST_RUN);
        // Ticks continue through a change; the new period starts at a wrap
        sys_clk_tick_next  = src_tick && (state_next == ST_RUN); // R8 R12 R20
        osc_range_next     = osc_range_type'(cfg_reg.source_select_cfg[`SRC_RANGE_MSB:`SRC_RANGE_LSB]); // R1
        pin_next.data      = port_out_data;
        pin_next.oe_n      = port_out_oe_n;
        if (state_reg != ST_LATCH && cfg_reg.clock_out_cfg && !crystal_src) begin // R13 R15
            pin_next.data = src_tick && (state_next == ST_RUN); // R16
            pin_next.oe_n = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_reg              <= fuse_cfg_type'({`SHIP_SOURCE_SEL, `SHIP_STARTUP, `SHIP_DIV8, `SHIP_CLKOUT}); // R7
            state_reg            <= ST_LATCH;
            delay_reg            <= 24'h00_0000;
            wake_pending_reg     <= 1'b0;
            sel_reg              <= `PS_RESET_DIV8;
            chg_en_reg           <= 1'b0;
            chg_cnt_reg          <= 3'h0;
            pending_reg          <= 1'b0;
            sys_clk_tick         <= 1'b0;
            clock_running        <= 1'b0;
            osc_range            <= RANGE_0P4_0P9;
            clock_out_pin.data   <= 1'b0; // R14
            clock_out_pin.oe_n   <= 1'b1;
        end else begin
            cfg_reg              <= cfg_next;
            state_reg            <= state_next;
            delay_reg            <= delay_next;
            wake_pending_reg     <= wake_pending_next;
            sel_reg              <= sel_next;
            chg_en_reg           <= chg_en_next;
            chg_cnt_reg          <= chg_cnt_next;
            pending_reg          <= pending_next;
            sys_clk_tick         <= sys_clk_tick_next;
            clock_running        <= clock_running_next;
            osc_range            <= osc_range_next;
            clock_out_pin        <= pin_next;
        end
    end

    always_comb begin
        prescale_control_reg = {chg_en_reg, 3'b000, sel_reg};
    end

endmodule

// ==== verification/clk_ctrl_asserts.sv ====
`timescale 1ns/1ps
module clk_ctrl_asserts
    import clock_ctrl_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          rst,
    input wire fuse_cfg_type  fuse_in,
    input wire logic          power_down_req,
    input wire logic          wake_req,
    input wire logic          cpu_wr,
    input wire logic [7:0]    cpu_wdata,
    input wire logic          port_out_data,
    input wire logic          port_out_oe_n,
    input wire logic          sys_clk_tick,
    input wire logic          clock_running,
    input wire osc_range_type osc_range,
    input wire logic [7:0]    prescale_control_reg,
    input wire pad_drive_type clock_out_pin
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [2:0] en_ticks_reg;
    logic [2:0] en_ticks_next;
    logic       ran_reg;
    logic       ran_next;
    logic       out_on;

    // Fuses never change while running, so the live inputs stand for the captured copy
    assign out_on = fuse_in.clock_out_cfg && !fuse_in.source_select_cfg[3] && fuse_in.source_select_cfg != 4'h6;

    always_comb begin
        en_ticks_next = en_ticks_reg;
        ran_next = ran_reg | clock_running;
        if (!prescale_control_reg[7]) begin
            en_ticks_next = 3'h0;
        end else if (sys_clk_tick && en_ticks_reg != 3'h7) begin
            en_ticks_next = en_ticks_reg + 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_ticks_reg <= 3'h0;
            ran_reg <= 1'b0;
        end else begin
            en_ticks_reg <= en_ticks_next;
            ran_reg <= ran_next;
        end
    end

    property p_range;
        clock_running && fuse_in.source_select_cfg[3] |-> osc_range == fuse_in.source_select_cfg[2:1];
    endproperty
    a_range: assert property (p_range) else $error("oscillator range mismatch");

    property p_boot_sel;
        $rose(clock_running) && !ran_reg |-> prescale_control_reg[3:0] == (fuse_in.div_by_eight_cfg ? 4'h3 : 4'h0);
    endproperty
    a_boot_sel: assert property (p_boot_sel) else $error("reset select wrong");

    property p_gate;
        !clock_running && !$past(clock_running) |-> !sys_clk_tick;
    endproperty
    a_gate: assert property (p_gate) else $error("tick while gated");

    property p_clkout;
        clock_running && out_on |-> clock_out_pin.data == sys_clk_tick && !clock_out_pin.oe_n;
    endproperty
    a_clkout: assert property (p_clkout) else $error("pin not carrying system clock");

    property p_idle_pin;
        !clock_running && out_on |-> !clock_out_pin.data;
    endproperty
    a_idle_pin: assert property (p_idle_pin) else $error("clock activity on pin");

    property p_xtal_pass;
        fuse_in.source_select_cfg[3] && clock_running && $stable({port_out_data, port_out_oe_n})
            |-> clock_out_pin == {port_out_data, port_out_oe_n};
    endproperty
    a_xtal_pass: assert property (p_xtal_pass) else $error("port function lost");

    property p_sel_change;
        clock_running && $past(clock_running) && $changed(prescale_control_reg[3:0])
            |-> $past(prescale_control_reg[7]);
    endproperty
    a_sel_change: assert property (p_sel_change) else $error("select changed without enable");

    property p_en_timeout;
        prescale_control_reg[7] |-> en_ticks_reg <= 3'h4;
    endproperty
    a_en_timeout: assert property (p_en_timeout) else $error("change enable outlived four ticks");

    property p_reserved;
        prescale_control_reg[6:4] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_tick_live;
        clock_running |-> ##[0:256] (sys_clk_tick || !clock_running);
    endproperty
    a_tick_live: assert property (p_tick_live) else $error("system clock stalled");

    c_boot: cover property ($rose(clock_running));
    c_change: cover property (cpu_wr && sys_clk_tick && prescale_control_reg[7]);
    c_sleep: cover property ($fell(clock_running));
endmodule

bind crystal_clock_prescale_output clk_ctrl_asserts clk_ctrl_asserts_inst (
    .core_clk(core_clk), .rst(rst), .fuse_in(fuse_in), .power_down_req(power_down_req), .wake_req(wake_req),
    .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .port_out_data(port_out_data), .port_out_oe_n(port_out_oe_n),
    .sys_clk_tick(sys_clk_tick), .clock_running(clock_running), .osc_range(osc_range),
    .prescale_control_reg(prescale_control_reg), .clock_out_pin(clock_out_pin));

// ==== verification/clock_sink.sv ====
`timescale 1ns/1ps
module clock_sink
    import clock_ctrl_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire pad_drive_type clock_out_pin,
    output logic [15:0]        edge_count
);
    logic        pad_level;
    logic        last_reg;
    logic [15:0] count_next;

    // A released pad floats to the board pull-up
    assign pad_level = clock_out_pin.oe_n ? 1'b1 : clock_out_pin.data;

    always_comb begin
        count_next = edge_count + ((pad_level && !last_reg) ? 16'h0001 : 16'h0000);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_reg <= 1'b1;
            edge_count <= 16'h0000;
        end else begin
            last_reg <= pad_level;
            edge_count <= count_next;
        end
    end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
    import clock_ctrl_pkg::*;
    localparam int SHORT = 20;
    localparam int LONG = 50;
    logic          core_clk, rst, power_down_req, wake_req, cpu_wr, port_out_data, port_out_oe_n;
    logic          sys_clk_tick, clock_running;
    logic [7:0]    cpu_wdata, prescale_control_reg;
    fuse_cfg_type  fuse_in, f;
    osc_range_type osc_range;
    pad_drive_type clock_out_pin;
    logic [15:0]   edge_count, e0;
    logic [31:0]   seed, r;
    logic [3:0]    sel;
    int            miscompares, n_tests, cycles, n, t1, t2, g1, g2, g3;

    crystal_clock_prescale_output #(.DLY_SHORT_CYC(SHORT), .DLY_LONG_CYC(LONG)) crystal_clock_prescale_output_inst (
        .core_clk(core_clk), .rst(rst), .fuse_in(fuse_in), .power_down_req(power_down_req), .wake_req(wake_req),
        .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .port_out_data(port_out_data), .port_out_oe_n(port_out_oe_n),
        .sys_clk_tick(sys_clk_tick), .clock_running(clock_running), .osc_range(osc_range),
        .prescale_control_reg(prescale_control_reg), .clock_out_pin(clock_out_pin));
    clock_sink clock_sink_inst (.core_clk(core_clk), .rst(rst), .clock_out_pin(clock_out_pin), .edge_count(edge_count));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int div_of(logic [3:0] s);
        return (s > 4'h8) ? 256 : (1 << s);
    endfunction

    function automatic int boot_cycles(fuse_cfg_type c);
        logic [2:0] k;
        int         osc;
        int         ext;
        k = {c.source_select_cfg[0], c.startup_time_cfg};
        osc = (k < 3'd2) ? 258 : (k < 3'd5) ? 1024 : 16384;
        ext = (k % 3 == 0) ? SHORT : (k % 3 == 1) ? LONG : 0;
        if (!c.source_select_cfg[3]) begin
            osc = 6;
            ext = (c.startup_time_cfg == 2'h0) ? 0 : (c.startup_time_cfg == 2'h1) ? SHORT : LONG;
        end
        return osc + 14 + ext;
    endfunction

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_win(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic wait_run(input logic v);
        n = 0;
        while (clock_running !== v && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    task automatic cpu_write(input logic [7:0] d);
        @(posedge core_clk);
        cpu_wr <= 1'b1;
        cpu_wdata <= d;
        @(posedge core_clk iff sys_clk_tick === 1'b1);
        cpu_wr <= 1'b0;
    endtask

    task automatic gap(output int p);
        p = 0;
        do begin
            @(posedge core_clk);
            p++;
        end while (sys_clk_tick !== 1'b1 && p < 600);
    endtask

    initial begin
        {rst, power_down_req, wake_req, cpu_wr, port_out_data, port_out_oe_n} = 6'b100_001;
        cpu_wdata = 8'h00;
        fuse_in = 8'h00;
        seed = 32'h0000_e275;
        {cycles, miscompares, n_tests} = 96'h0;
        for (int i = 0; i < 11; i++) begin
            // Lowest range and 258-cycle starts appear only with resonator start codes
            f = (i < 8) ? {1'b1, 2'(i), 1'(i >> 2), 2'(i), 1'(i), 1'b1} : {4'h2, 2'(i - 8), 2'b11};
            @(posedge core_clk);
            rst <= 1'b1;
            fuse_in <= f;
            port_out_data <= 1'b0;
            port_out_oe_n <= 1'b1;
            repeat (10) @(posedge core_clk);
            rst <= 1'b0;
            wait_run(1'b1);
            check_win(n, boot_cycles(f), boot_cycles(f) + 5);
            check_val(prescale_control_reg, {6'h00, f.div_by_eight_cfg, f.div_by_eight_cfg});
            if (i < 8) begin
                check_val(osc_range, f.source_select_cfg[2:1]);
                r = xorshift();
                port_out_data <= r[0];
                port_out_oe_n <= r[1];
                repeat (3) @(posedge core_clk);
                check_val(clock_out_pin, {r[0], r[1]});
            end
            $display("boot test %0d done", i);
        end
        gap(t1);
        gap(t1);
        check_val(t1, 8);
        cpu_write(8'h02);
        cpu_write(8'h81);
        @(posedge core_clk);
        check_val(prescale_control_reg, 8'h03);
        cpu_write(8'h80);
        @(posedge core_clk);
        check_val(prescale_control_reg, 8'h83);
        repeat (5) @(posedge core_clk iff sys_clk_tick === 1'b1);
        cpu_write(8'h01);
        @(posedge core_clk);
        check_val(prescale_control_reg, 8'h03);
        $display("refusal test done");
        for (int j = 0; j < 8; j++) begin
            r = xorshift();
            sel = (j < 3) ? 4'(j * 4) : (j == 3) ? 4'hc : r[3:0];
            t2 = div_of(sel);
            cpu_write(8'h80);
            cpu_write({4'h0, sel});
            gap(g1);
            gap(g2);
            gap(g3);
            check_win(g1, (t1 < t2) ? t1 : t2, t1);
            check_win(g1 + g2, t1 + t2, t1 + 2 * t2);
            check_val(g3, t2);
            check_val(prescale_control_reg, {4'h0, sel});
            e0 = edge_count;
            repeat (4) gap(g3);
            check_val(edge_count - e0, (t2 > 1) ? 4 : 0);
            t1 = t2;
            $display("divide test %0d done", j);
        end
        power_down_req <= 1'b1;
        wait_run(1'b0);
        power_down_req <= 1'b0;
        @(posedge core_clk);
        wake_req <= 1'b1;
        @(posedge core_clk);
        wake_req <= 1'b0;
        wait_run(1'b1);
        check_win(n, 5, 10);
        $display("wake test done");
        summarize();
    end
endmodule
